// file: rxim_pkg.sv
// Package: register map, field positions and reset values of the rx irq mask block
package rxim_pkg;

    localparam int RXIM_CHANNELS = 8;
    localparam int RXIM_ENABLE_W = 16;
    localparam int RXIM_MAC_W    = 2;
    localparam int RXIM_EVT_W    = 18;
    localparam int RXIM_ADDR_W   = 8;
    localparam int RXIM_DATA_W   = 32;
    localparam int RXIM_BE_W     = 4;

    localparam logic [7:0] RXIM_OFS_ENABLE_SET   = 8'h00;
    localparam logic [7:0] RXIM_OFS_ENABLE_CLEAR = 8'h04;
    localparam logic [7:0] RXIM_OFS_MAC_RAW      = 8'h08;
    localparam logic [7:0] RXIM_OFS_RX_RAW       = 8'h0C;
    localparam logic [7:0] RXIM_OFS_RX_MASKED    = 8'h10;
    localparam logic [7:0] RXIM_OFS_EVT_STATUS   = 8'h14;
    localparam logic [7:0] RXIM_OFS_EVT_MASK     = 8'h18;

    localparam int RXIM_RECV_LSB    = 0;
    localparam int RXIM_THRESH_LSB  = 8;
    localparam int RXIM_STAT_BIT    = 0;
    localparam int RXIM_HOST_BIT    = 1;
    localparam int RXIM_EVT_MAC_LSB = 16;

    localparam logic [15:0] RXIM_ENABLE_RST   = 16'h0000;
    localparam logic [17:0] RXIM_EVT_MASK_RST = 18'h00000;
    localparam logic [31:0] RXIM_RDATA_RST    = 32'h00000000;
    localparam logic [31:0] RXIM_UNMAPPED_RD  = 32'h00000000;

    typedef enum logic [0:0] {
        RXIM_BUS_IDLE = 1'b0,
        RXIM_BUS_ACK  = 1'b1
    } rxim_bus_t;

endpackage

// file: rxim_sticky.sv
// Sticky event status with write-one-to-clear and masked level interrupt
`timescale 1ns/1ps
`default_nettype none
module rxim_sticky #(
    parameter int W = 18
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set_evt,
    input  wire logic [W-1:0] clr,
    input  wire logic [W-1:0] mask,
    output var  logic [W-1:0] status,
    output var  logic         irq
);
    import rxim_pkg::*;

    typedef struct packed {
        logic [W-1:0] status;
        logic         irq;
    } rxim_sticky_state_t;

    rxim_sticky_state_t state_q;
    rxim_sticky_state_t state_d;

    always_comb begin
        state_d        = state_q;
        // Set wins over a clear in the same cycle
        state_d.status = (state_q.status & ~clr) | set_evt;
        state_d.irq    = |(state_d.status & mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign status = state_q.status;
    assign irq    = state_q.irq;
endmodule
`default_nettype wire

// file: rxim_sync.sv
// Two-stage synchroniser for a vector of pending levels
`timescale 1ns/1ps
`default_nettype none
module rxim_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    import rxim_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rxim_sync_state_t;

    rxim_sync_state_t state_q;
    rxim_sync_state_t state_d;

    always_comb begin
        state_d        = state_q;
        state_d.meta   = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;
endmodule
`default_nettype wire

// file: rxim_top.sv
// Receive interrupt enable masks, raw and masked status views, Avalon-MM slave
//
// Summary of operation
// - Writing one to set bits 15..8 enables threshold irq of channel bit-8.
// - Writing one to set bits 7..0 enables receive irq of that channel.
// - Zero bits written to the set register leave enables unchanged.
// - Writing one to clear bits 15..8 disables threshold irq of channel bit-8.
// - Writing one to clear bits 7..0 disables receive irq of that channel.
// - Zero bits written to the clear register leave enables unchanged.
// - All sixteen enables reset to zero; bits 31..16 read zero.
// - MAC raw status bit 1 shows host error pending before masking.
// - MAC raw status bit 0 shows statistics pending before masking.
// - MAC raw status is read-only; bits 31..2 read zero.
// - Per channel raw threshold and receive pending sit in bits 15..8, 7..0.
// - Masked receive status is raw pending ANDed with the channel enable.
`timescale 1ns/1ps
`default_nettype none
module rxim_top #(
    parameter int CHANNELS = rxim_pkg::RXIM_CHANNELS
) (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic [rxim_pkg::RXIM_ADDR_W-1:0] avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [rxim_pkg::RXIM_DATA_W-1:0] avs_writedata,
    input  wire logic [rxim_pkg::RXIM_BE_W-1:0]   avs_byteenable,
    output var  logic [rxim_pkg::RXIM_DATA_W-1:0] avs_readdata,
    output var  logic                            avs_waitrequest,
    input  wire logic [CHANNELS-1:0]             rx_thresh_pending,
    input  wire logic [CHANNELS-1:0]             rx_recv_pending,
    input  wire logic                            host_error_pending,
    input  wire logic                            statistics_pending,
    output var  logic [CHANNELS-1:0]             rx_thresh_irq,
    output var  logic [CHANNELS-1:0]             rx_recv_irq,
    output var  logic [2*CHANNELS-1:0]           rx_irq_enable,
    output var  logic                            irq
);
    import rxim_pkg::*;

    localparam int EW = 2 * CHANNELS;
    localparam int VW = EW + RXIM_MAC_W;

    typedef struct packed {
        rxim_bus_t         bus;
        logic              waitreq;
        logic [31:0]       rdata;
        logic [EW-1:0]     enable;
        logic [VW-1:0]     evt_mask;
        logic [EW-1:0]     rx_masked;
        logic [VW-1:0]     prev_src;
    } rxim_state_t;

    rxim_state_t state_q;
    rxim_state_t state_d;

    logic [EW-1:0]           rx_raw_async;
    logic [EW-1:0]           rx_raw;
    logic [RXIM_MAC_W-1:0]   mac_raw_async;
    logic [RXIM_MAC_W-1:0]   mac_raw;
    logic [VW-1:0]           src_now;
    logic [VW-1:0]           evt_set;
    logic [VW-1:0]           evt_clr;
    logic [VW-1:0]           evt_status;
    logic                    sticky_irq;
    logic [31:0]             be_mask;
    logic [31:0]             wdata_eff;
    logic [31:0]             rd_mux;
    logic                    req;
    logic                    wr_take;

    // Raw per channel view: threshold above, receive below
    always_comb begin
        rx_raw_async = '0;
        rx_raw_async[RXIM_THRESH_LSB +: CHANNELS] = rx_thresh_pending;
        rx_raw_async[RXIM_RECV_LSB +: CHANNELS]   = rx_recv_pending;
        mac_raw_async = '0;
        mac_raw_async[RXIM_HOST_BIT] = host_error_pending;
        mac_raw_async[RXIM_STAT_BIT] = statistics_pending;
    end

    rxim_sync #(
        .W (EW)
    ) u_sync_rx (
        .clk      (clk),
        .rst      (rst),
        .async_in (rx_raw_async),
        .sync_out (rx_raw)
    );

    rxim_sync #(
        .W (RXIM_MAC_W)
    ) u_sync_mac (
        .clk      (clk),
        .rst      (rst),
        .async_in (mac_raw_async),
        .sync_out (mac_raw)
    );

    // Event sources: threshold and receive pending bits below, MAC pending bits above
    assign src_now = {mac_raw, rx_raw};
    assign evt_set = src_now & ~state_q.prev_src;

    // Byte lane expansion
    always_comb begin
        be_mask = '0;
        for (int i = 0; i < RXIM_BE_W; i++) begin
            be_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
    end

    assign wdata_eff = avs_writedata & be_mask;
    assign req       = avs_read | avs_write;
    assign wr_take   = (state_q.bus == RXIM_BUS_ACK) && avs_write;

    // Event status clear strobe, applied at the accepting edge
    always_comb begin
        evt_clr = '0;
        if (wr_take && (avs_address == RXIM_OFS_EVT_STATUS)) begin
            evt_clr = wdata_eff[VW-1:0];
        end
    end

    rxim_sticky #(
        .W (VW)
    ) u_sticky (
        .clk     (clk),
        .rst     (rst),
        .set_evt (evt_set),
        .clr     (evt_clr),
        .mask    (state_q.evt_mask),
        .status  (evt_status),
        .irq     (sticky_irq)
    );

    // Read data selection
    always_comb begin
        rd_mux = RXIM_UNMAPPED_RD;
        case (avs_address)
            RXIM_OFS_ENABLE_SET: begin
                rd_mux[EW-1:0] = state_q.enable;
            end
            RXIM_OFS_ENABLE_CLEAR: begin
                rd_mux[EW-1:0] = state_q.enable;
            end
            RXIM_OFS_MAC_RAW: begin
                rd_mux[RXIM_MAC_W-1:0] = mac_raw;
            end
            RXIM_OFS_RX_RAW: begin
                rd_mux[EW-1:0] = rx_raw;
            end
            RXIM_OFS_RX_MASKED: begin
                rd_mux[EW-1:0] = rx_raw & state_q.enable;
            end
            RXIM_OFS_EVT_STATUS: begin
                rd_mux[VW-1:0] = evt_status;
            end
            RXIM_OFS_EVT_MASK: begin
                rd_mux[VW-1:0] = state_q.evt_mask;
            end
            default: begin
                rd_mux = RXIM_UNMAPPED_RD;
            end
        endcase
    end

    // Next state
    always_comb begin
        state_d           = state_q;
        state_d.prev_src  = src_now;
        state_d.rx_masked = rx_raw & state_q.enable;
        case (state_q.bus)
            RXIM_BUS_IDLE: begin
                if (req) begin
                    state_d.bus     = RXIM_BUS_ACK;
                    state_d.waitreq = 1'b0;
                    state_d.rdata   = avs_read ? rd_mux : RXIM_RDATA_RST;
                end
            end
            RXIM_BUS_ACK: begin
                state_d.bus     = RXIM_BUS_IDLE;
                state_d.waitreq = 1'b1;
                if (wr_take) begin
                    case (avs_address)
                        RXIM_OFS_ENABLE_SET: begin
                            // Ones set, zeros keep
                            state_d.enable = state_q.enable
                                           | wdata_eff[EW-1:0];
                        end
                        RXIM_OFS_ENABLE_CLEAR: begin
                            // Ones clear, zeros keep
                            state_d.enable = state_q.enable
                                           & ~wdata_eff[EW-1:0];
                        end
                        RXIM_OFS_EVT_MASK: begin
                            state_d.evt_mask = (state_q.evt_mask & ~be_mask[VW-1:0])
                                             | wdata_eff[VW-1:0];
                        end
                        default: begin
                            // Read-only and unmapped writes are dropped
                            state_d.enable = state_q.enable;
                        end
                    endcase
                end
            end
            default: begin
                state_d.bus     = RXIM_BUS_IDLE;
                state_d.waitreq = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q.bus       <= RXIM_BUS_IDLE;
            state_q.waitreq   <= 1'b1;
            state_q.rdata     <= RXIM_RDATA_RST;
            state_q.enable    <= RXIM_ENABLE_RST[EW-1:0];
            state_q.evt_mask  <= RXIM_EVT_MASK_RST[VW-1:0];
            state_q.rx_masked <= '0;
            state_q.prev_src  <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata    = state_q.rdata;
    assign avs_waitrequest = state_q.waitreq;
    assign rx_thresh_irq   = state_q.rx_masked[RXIM_THRESH_LSB +: CHANNELS];
    assign rx_recv_irq     = state_q.rx_masked[RXIM_RECV_LSB +: CHANNELS];
    assign rx_irq_enable   = state_q.enable;
    assign irq             = sticky_irq;
endmodule
`default_nettype wire

// file: rxim_top_asserts.sv
// Port checker of the rx irq mask block
`timescale 1ns/1ps
`default_nettype none
module rxim_top_asserts #(
    parameter int CHANNELS = rxim_pkg::RXIM_CHANNELS
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic [7:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_writedata,
    input wire logic [3:0]            avs_byteenable,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic [CHANNELS-1:0]   rx_thresh_irq,
    input wire logic [CHANNELS-1:0]   rx_recv_irq,
    input wire logic [2*CHANNELS-1:0] rx_irq_enable,
    input wire logic                  irq
);
    import rxim_pkg::*;
    logic [15:0] wm;
    logic        acc_w;
    logic        acc_r;
    assign wm = avs_writedata[15:0] & {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign acc_w = avs_write && !avs_waitrequest;
    assign acc_r = avs_read && !avs_waitrequest;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_TAKE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_SET: assert property (acc_w && avs_address == RXIM_OFS_ENABLE_SET |=>
        rx_irq_enable == ($past(rx_irq_enable) | $past(wm))) else $error("set write wrong");
    AST_CLR: assert property (acc_w && avs_address == RXIM_OFS_ENABLE_CLEAR |=>
        rx_irq_enable == ($past(rx_irq_enable) & ~$past(wm))) else $error("clear write wrong");
    AST_HOLD: assert property ($changed(rx_irq_enable) |-> $past(acc_w &&
        (avs_address == RXIM_OFS_ENABLE_SET || avs_address == RXIM_OFS_ENABLE_CLEAR)))
        else $error("enables changed alone");
    AST_RDEN: assert property (acc_r && (avs_address == RXIM_OFS_ENABLE_SET ||
        avs_address == RXIM_OFS_ENABLE_CLEAR) |-> avs_readdata == {16'h0000, rx_irq_enable})
        else $error("enable readback wrong");
    AST_MACRO: assert property (acc_r && avs_address == RXIM_OFS_MAC_RAW |->
        avs_readdata[31:2] == 30'h00000000) else $error("raw status upper bits set");
    AST_RST: assert property (disable iff (1'b0) $fell(rst) |-> rx_irq_enable == '0 &&
        rx_thresh_irq == '0 && rx_recv_irq == '0 && !irq && avs_waitrequest)
        else $error("reset state wrong");
    AST_MASK: assert property ((rx_recv_irq & ~(rx_irq_enable[CHANNELS-1:0] |
        $past(rx_irq_enable[CHANNELS-1:0]))) == '0 && (rx_thresh_irq &
        ~(rx_irq_enable[2*CHANNELS-1:CHANNELS] | $past(rx_irq_enable[2*CHANNELS-1:CHANNELS])))
        == '0) else $error("irq without enable");
    COV_SET: cover property (acc_w && avs_address == RXIM_OFS_ENABLE_SET);
    COV_CLR: cover property (acc_w && avs_address == RXIM_OFS_ENABLE_CLEAR);
    COV_IRQ: cover property ($rose(irq));
endmodule
bind rxim_top rxim_top_asserts #(.CHANNELS(CHANNELS)) chk_u (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_thresh_irq(rx_thresh_irq), .rx_recv_irq(rx_recv_irq),
    .rx_irq_enable(rx_irq_enable), .irq(irq));
`default_nettype wire

// file: rxim_top_test.sv
// Self-checking bench of the rx irq mask block
`timescale 1ns/1ps
`default_nettype none
module rxim_top_test;
    import rxim_pkg::*;
    logic        clk, rst, rd, wr, hst, sta, irq, wreq, c;
    logic [3:0]  bena, be;
    logic [7:0]  adr, thr, rcv, t_irq, r_irq;
    logic [15:0] en_o, e;
    logic [31:0] wdat, rdat, q, d;
    int          n_tests = 0;
    int          n_mismatch = 0;
    int          i;
    rxim_top dut_u (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(bena), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .rx_thresh_pending(thr), .rx_recv_pending(rcv),
        .host_error_pending(hst), .statistics_pending(sta), .rx_thresh_irq(t_irq),
        .rx_recv_irq(r_irq), .rx_irq_enable(en_o), .irq(irq));
    function automatic logic [15:0] nxt(logic [15:0] v, logic cl, logic [31:0] x, logic [3:0] b);
        logic [15:0] m;
        m = x[15:0] & {{8{b[1]}}, {8{b[0]}}};
        return cl ? (v & ~m) : (v | m);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] x,
                       input logic [3:0] b, output logic [31:0] r);
        int n;
        @(posedge clk);
        adr <= a;
        wdat <= x;
        bena <= b;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        r = rdat;
        if (n >= 50) n_mismatch++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h00000000, 4'h0, r);
        chk(r, exp);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {rst, rd, wr, hst, sta, bena, adr, thr, rcv, wdat} = {1'b1, 64'h0};
        e = 16'h0000;
        void'($urandom(60977));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) rdc(8'(i * 4), 32'h00000000);
        bus(RXIM_OFS_MAC_RAW, 1'b1, 32'hFFFFFFFF, 4'hF, q);
        bus(8'h3C, 1'b1, 32'hFFFFFFFF, 4'hF, q);
        rdc(RXIM_OFS_MAC_RAW, 32'h00000000);
        rdc(8'h3C, 32'h00000000);
        $display("reset and read-only test done");
        for (i = 0; i < 40; i++) begin
            c = (i == 0) ? 1'b0 : 1'($urandom_range(1, 0));
            d = (i < 2) ? 32'hFFFFFFFF : $urandom;
            be = (i < 2) ? 4'hF : 4'($urandom);
            bus(c ? RXIM_OFS_ENABLE_CLEAR : RXIM_OFS_ENABLE_SET, 1'b1, d, be, q);
            e = nxt(e, c, d, be);
            rdc(RXIM_OFS_ENABLE_SET, {16'h0000, e});
            rdc(RXIM_OFS_ENABLE_CLEAR, {16'h0000, e});
            chk(32'(en_o), 32'(e));
        end
        $display("enable set and clear test done");
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            thr <= 8'($urandom);
            rcv <= 8'($urandom);
            {hst, sta} <= (i < 4) ? 2'(i) : 2'($urandom);
            repeat (4) @(posedge clk);
            rdc(RXIM_OFS_RX_RAW, {16'h0000, thr, rcv});
            rdc(RXIM_OFS_RX_MASKED, {16'h0000, thr & e[15:8], rcv & e[7:0]});
            rdc(RXIM_OFS_MAC_RAW, {30'h00000000, hst, sta});
            chk({16'h0000, t_irq, r_irq}, {16'h0000, thr & e[15:8], rcv & e[7:0]});
        end
        $display("pending status test done");
        @(posedge clk);
        sta <= 1'b0;
        repeat (4) @(posedge clk);
        bus(RXIM_OFS_EVT_STATUS, 1'b1, 32'h0003FFFF, 4'hF, q);
        bus(RXIM_OFS_EVT_MASK, 1'b1, 32'h00010000, 4'hF, q);
        rdc(RXIM_OFS_EVT_MASK, 32'h00010000);
        rdc(RXIM_OFS_EVT_STATUS, 32'h00000000);
        chk(32'(irq), 32'h0);
        @(posedge clk);
        sta <= 1'b1;
        repeat (5) @(posedge clk);
        chk(32'(irq), 32'h1);
        rdc(RXIM_OFS_EVT_STATUS, 32'h00010000);
        bus(RXIM_OFS_EVT_MASK, 1'b1, 32'h00000000, 4'h0, q);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        bus(RXIM_OFS_EVT_MASK, 1'b1, 32'h00000000, 4'h4, q);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        bus(RXIM_OFS_EVT_MASK, 1'b1, 32'h00010000, 4'hF, q);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        bus(RXIM_OFS_EVT_STATUS, 1'b1, 32'h00010000, 4'hF, q);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("interrupt test done");
        stop_test();
    end
endmodule
`default_nettype wire
